// File: design/spcc_pkg.sv
// Constants, field layout and state type of the serial port setup block
package spcc_pkg;
    localparam int SPCC_ADDR_W = 15;
    localparam logic [14:0] SPCC_ADDR_SETUP_A = 15'h0000;
    localparam logic [14:0] SPCC_ADDR_SETUP_B = 15'h0001;
    localparam logic [14:0] SPCC_ADDR_UPDATE = 15'h000F;
    localparam logic [14:0] SPCC_ADDR_BUF_BASE = 15'h0010;
    localparam logic [7:0] SPCC_UPDATE_KEY = 8'h01;
    localparam logic [7:0] SPCC_SETUP_RESET = 8'h00;
    // Setup A fields, each held twice
    localparam int SPCC_A_RESET_HI = 7;
    localparam int SPCC_A_LSB_HI = 6;
    localparam int SPCC_A_ASC_HI = 5;
    localparam int SPCC_A_WIRE_HI = 4;
    localparam int SPCC_A_WIRE_LO = 3;
    localparam int SPCC_A_ASC_LO = 2;
    localparam int SPCC_A_LSB_LO = 1;
    localparam int SPCC_A_RESET_LO = 0;
    // Setup B fields
    localparam int SPCC_B_SINGLE = 7;
    localparam int SPCC_B_RDBUF = 5;
    localparam int SPCC_B_CAL = 2;
    localparam int SPCC_B_RESYNC = 1;
    // Frame layout: 16 instruction bits, read flag on top
    localparam logic [3:0] SPCC_INSTR_LAST = 4'hF;
    localparam logic [3:0] SPCC_BYTE_LAST = 4'h7;
    localparam int SPCC_RW_BIT = 15;
    // Outputs stay stalled this many clocks around a divider reset
    localparam logic [3:0] SPCC_RESYNC_CYCLES = 4'h4;
    localparam int SPCC_DEF_BUF_DEPTH = 8;
    typedef enum logic [1:0] {SPCC_IDLE, SPCC_INSTR, SPCC_DATA, SPCC_SKIP} spcc_state_type;
endpackage

// File: design/spcc_link_if.sv
// Synchronised serial pin events passed from the pin sampler to the core
`timescale 1ns/1ps
interface spcc_link_if;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;
    logic serial_in_pin;
    modport sync_side (output sclk_rise, output sclk_fall, output cs_active, output serial_in_pin);
    modport core_side (input sclk_rise, input sclk_fall, input cs_active, input serial_in_pin);
endinterface

// File: design/spcc_pin_sync.sv
// Two-stage synchroniser and serial clock edge finder for the serial pins
`timescale 1ns/1ps
module spcc_pin_sync (
    input wire logic clk_i,             // System clock
    input wire logic rst_n_i,           // Synchronous reset, active low
    input wire logic sclk_i,            // Serial clock pin
    input wire logic csb_n_i,           // Chip select pin, active low
    input wire logic sdi_i,             // Serial data in pin
    spcc_link_if.sync_side link         // Synchronised events
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stab;
        logic sclk_prev;
    } spcc_sync_type;

    spcc_sync_type s_reg;
    spcc_sync_type s_next;

    // First stage feeds only the second; edges are found on later stages
    always_comb begin
        s_next = s_reg;
        s_next.meta = {sclk_i, csb_n_i, sdi_i};
        s_next.stab = s_reg.meta;
        s_next.sclk_prev = s_reg.stab[2];
    end

    // Chip select idles high so reset brings it up inactive
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_reg <= '{meta: 3'h2, stab: 3'h2, sclk_prev: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.sclk_rise = s_reg.stab[2] & ~s_reg.sclk_prev;
    assign link.sclk_fall = ~s_reg.stab[2] & s_reg.sclk_prev;
    assign link.cs_active = ~s_reg.stab[1];
    assign link.serial_in_pin = s_reg.stab[0];
endmodule

// File: design/spcc_serial_setup.sv
// Serial port slave with setup registers, buffered bank and control strobes
`timescale 1ns/1ps
module spcc_serial_setup #(
    parameter int BUF_DEPTH = spcc_pkg::SPCC_DEF_BUF_DEPTH
) (
    input wire logic clk_i,                            // System clock, 10 MHz
    input wire logic rst_n_i,                          // Synchronous reset, active low
    input wire logic sclk_i,                           // Serial clock pin
    input wire logic csb_n_i,                          // Chip select pin, active low
    input wire logic serial_in_pin_i,                  // Data pin, input side
    output logic serial_in_pin_o,                      // Data pin, 3-wire readback
    output logic serial_in_pin_oe_o,                   // Data pin drive enable
    output logic serial_out_pin_o,                     // Out pin, 4-wire readback
    output logic serial_out_pin_oe_o,                  // Out pin drive enable
    output logic [BUF_DEPTH*8-1:0] active_regs_o,      // Applied buffered settings
    output logic device_reset_o,                       // Whole device reset pulse
    output logic cal_start_o,                          // Oscillator calibration pulse
    output logic divider_reset_o,                      // Divider reset pulse
    output logic outputs_stall_o                       // Outputs held during resync
);
    import spcc_pkg::*;

    localparam int IDX_W = $clog2(BUF_DEPTH);

    typedef struct packed {
        spcc_state_type st;
        logic [3:0] bit_cnt;
        logic [15:0] instr;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [14:0] addr;
        logic rd;
        logic out_bit;
        logic drive;
        logic lsb;
        logic asc;
        logic four;
        logic single;
        logic rdbuf;
        logic [BUF_DEPTH-1:0][7:0] pend;
        logic [BUF_DEPTH-1:0][7:0] act;
        logic dev_rst;
        logic cal;
        logic div_rst;
        logic [3:0] rs_cnt;
    } spcc_core_type;

    localparam spcc_core_type CORE_RESET = '0;

    spcc_core_type s_reg;
    spcc_core_type s_next;
    spcc_link_if link();
    logic [7:0] rx_full;
    logic [15:0] instr_full;
    logic [14:0] buf_off;
    logic in_buf;
    logic byte_done;
    logic wr_fire;
    logic soft_hit;
    logic resync_hit;

    initial begin
        if (BUF_DEPTH < 2 || (1 << IDX_W) != BUF_DEPTH || BUF_DEPTH > 256) begin
            $error("BUF_DEPTH must be a power of two from 2 to 256");
        end
    end

    spcc_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sclk_i(sclk_i),
        .csb_n_i(csb_n_i),
        .sdi_i(serial_in_pin_i),
        .link(link)
    );

    // Readback view; mirrored fields come from one stored copy
    function automatic logic [7:0] read_mux(input spcc_core_type v, input logic [14:0] a);
        logic [14:0] off;
        logic [7:0] d;
        off = a - SPCC_ADDR_BUF_BASE;
        d = 8'h00;
        if (a == SPCC_ADDR_SETUP_A) begin
            d = {1'b0, v.lsb, v.asc, v.four, v.four, v.asc, v.lsb, 1'b0};
        end else if (a == SPCC_ADDR_SETUP_B) begin
            d[SPCC_B_SINGLE] = v.single;
            d[SPCC_B_RDBUF] = v.rdbuf;
        end else if (off < 15'(BUF_DEPTH)) begin
            d = v.rdbuf ? v.pend[off[IDX_W-1:0]] : v.act[off[IDX_W-1:0]];
        end
        return d;
    endfunction

    // Shift paths follow the live bit order
    assign rx_full = s_reg.lsb ? {link.serial_in_pin, s_reg.rx[7:1]} : {s_reg.rx[6:0], link.serial_in_pin};
    assign instr_full = s_reg.lsb ? {link.serial_in_pin, s_reg.instr[15:1]}
                                  : {s_reg.instr[14:0], link.serial_in_pin};
    assign buf_off = s_reg.addr - SPCC_ADDR_BUF_BASE;
    assign in_buf = buf_off < 15'(BUF_DEPTH);
    assign byte_done = link.cs_active && link.sclk_rise && s_reg.st == SPCC_DATA
                       && s_reg.bit_cnt == SPCC_BYTE_LAST;
    assign wr_fire = byte_done && !s_reg.rd;
    assign soft_hit = wr_fire && s_reg.addr == SPCC_ADDR_SETUP_A
                      && (rx_full[SPCC_A_RESET_HI] | rx_full[SPCC_A_RESET_LO]);
    assign resync_hit = wr_fire && s_reg.addr == SPCC_ADDR_SETUP_B
                        && (rx_full[SPCC_B_RESYNC] | rx_full[SPCC_B_CAL]);

    // Frame sequencing, register writes and strobes
    always_comb begin
        s_next = s_reg;
        s_next.dev_rst = 1'b0;
        s_next.cal = 1'b0;
        s_next.div_rst = 1'b0;
        if (s_reg.rs_cnt != 4'h0) begin
            s_next.rs_cnt = s_reg.rs_cnt - 4'h1;
        end
        if (!link.cs_active) begin
            s_next.st = SPCC_IDLE;
            s_next.drive = 1'b0;
        end else begin
            case (s_reg.st)
                SPCC_IDLE: begin
                    s_next.st = SPCC_INSTR;
                    s_next.bit_cnt = 4'h0;
                end
                SPCC_INSTR: begin
                    if (link.sclk_rise) begin
                        s_next.instr = instr_full;
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                        if (s_reg.bit_cnt == SPCC_INSTR_LAST) begin
                            s_next.rd = instr_full[SPCC_RW_BIT];
                            s_next.addr = instr_full[14:0];
                            s_next.bit_cnt = 4'h0;
                            s_next.st = SPCC_DATA;
                            s_next.tx = read_mux(s_reg, instr_full[14:0]);
                        end
                    end
                end
                SPCC_DATA: begin
                    // Read data changes on falling edges so the host samples it on rising
                    if (link.sclk_fall && s_reg.rd) begin
                        s_next.out_bit = s_reg.lsb ? s_reg.tx[0] : s_reg.tx[7];
                        s_next.tx = s_reg.lsb ? {1'b0, s_reg.tx[7:1]} : {s_reg.tx[6:0], 1'b0};
                        s_next.drive = 1'b1;
                    end
                    if (link.sclk_rise) begin
                        s_next.rx = rx_full;
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end
                    if (wr_fire) begin
                        if (s_reg.addr == SPCC_ADDR_SETUP_A) begin
                            // Either copy sets the field; takes effect on the next bit
                            s_next.lsb = rx_full[SPCC_A_LSB_HI] | rx_full[SPCC_A_LSB_LO];
                            s_next.asc = rx_full[SPCC_A_ASC_HI] | rx_full[SPCC_A_ASC_LO];
                            s_next.four = rx_full[SPCC_A_WIRE_HI] | rx_full[SPCC_A_WIRE_LO];
                        end else if (s_reg.addr == SPCC_ADDR_SETUP_B) begin
                            s_next.single = rx_full[SPCC_B_SINGLE];
                            s_next.rdbuf = rx_full[SPCC_B_RDBUF];
                            s_next.cal = rx_full[SPCC_B_CAL];
                            if (resync_hit) begin
                                s_next.div_rst = 1'b1;
                                s_next.rs_cnt = SPCC_RESYNC_CYCLES;
                            end
                        end else if (s_reg.addr == SPCC_ADDR_UPDATE) begin
                            if (rx_full == SPCC_UPDATE_KEY) begin
                                s_next.act = s_reg.pend;
                            end
                        end else if (in_buf) begin
                            s_next.pend[buf_off[IDX_W-1:0]] = rx_full;
                        end
                    end
                    if (byte_done) begin
                        s_next.bit_cnt = 4'h0;
                        if (s_next.single) begin
                            s_next.st = SPCC_SKIP;
                            s_next.drive = 1'b0;
                        end else begin
                            s_next.addr = s_next.asc ? s_reg.addr + 15'h0001
                                                     : s_reg.addr - 15'h0001;
                            s_next.tx = read_mux(s_next, s_next.addr);
                        end
                    end
                end
                SPCC_SKIP: begin
                    s_next.drive = 1'b0;
                end
                default: begin
                    s_next.st = SPCC_IDLE;
                end
            endcase
        end
        // Soft reset clears everything and drops the rest of the frame
        if (soft_hit) begin
            s_next = CORE_RESET;
            s_next.dev_rst = 1'b1;
            s_next.st = SPCC_SKIP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_reg <= CORE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Only one data pin ever drives, chosen by the live wire mode
    assign serial_in_pin_o = s_reg.out_bit;
    assign serial_in_pin_oe_o = s_reg.drive & ~s_reg.four;
    assign serial_out_pin_o = s_reg.out_bit;
    assign serial_out_pin_oe_o = s_reg.drive & s_reg.four;
    assign active_regs_o = s_reg.act;
    assign device_reset_o = s_reg.dev_rst;
    assign cal_start_o = s_reg.cal;
    assign divider_reset_o = s_reg.div_rst;
    assign outputs_stall_o = s_reg.rs_cnt != 4'h0;

    a_update_copies: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_fire && s_reg.addr == SPCC_ADDR_UPDATE && rx_full == SPCC_UPDATE_KEY
        |=> active_regs_o == $past(s_reg.pend)) else $error("update did not apply pending");
    a_live_order: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_fire && s_reg.addr == SPCC_ADDR_SETUP_A && !soft_hit
        |=> s_reg.lsb == $past(rx_full[6] | rx_full[1])) else $error("bit order not live");
    a_soft_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        soft_hit |=> device_reset_o && read_mux(s_reg, SPCC_ADDR_SETUP_A) == SPCC_SETUP_RESET
        ##1 !device_reset_o) else $error("soft reset wrong");
    a_bit_order: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        link.cs_active && link.sclk_fall && s_reg.st == SPCC_DATA && s_reg.rd
        |=> s_reg.out_bit == $past(s_reg.lsb ? s_reg.tx[0] : s_reg.tx[7]))
        else $error("read bit order wrong");
    a_addr_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        byte_done && !s_reg.single && !soft_hit && !(wr_fire && s_reg.addr <= 15'h0001)
        |=> s_reg.addr == $past(s_reg.asc ? s_reg.addr + 15'h0001 : s_reg.addr - 15'h0001))
        else $error("stream address step wrong");
    a_pin_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        serial_out_pin_oe_o |-> s_reg.four && !serial_in_pin_oe_o) else $error("pin mode wrong");
    a_single_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        byte_done && s_reg.single && !(wr_fire && s_reg.addr == SPCC_ADDR_SETUP_B)
        |=> s_reg.st == SPCC_SKIP || !link.cs_active) else $error("single mode kept going");
    a_cal_resync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_fire && s_reg.addr == SPCC_ADDR_SETUP_B && rx_full[SPCC_B_CAL]
        |=> cal_start_o && divider_reset_o) else $error("calibration lacks resync");
    a_resync_seq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        resync_hit |=> divider_reset_o && outputs_stall_o
        ##1 (outputs_stall_o && !divider_reset_o) [*3] ##1 !outputs_stall_o)
        else $error("resync sequence wrong");
endmodule

// File: testbench/spcc_host_model.sv
// Behavioural serial host that clocks frames into the setup block
`timescale 1ns/1ps
module spcc_host_model (
    input wire logic clk_i,        // System clock, used for pacing only
    input wire logic pin_in_i,     // Resolved level of the two-way data pin
    input wire logic out_pin_i,    // Level seen on the out pin
    output logic sclk_o,           // Serial clock, idles low
    output logic csb_n_o,          // Chip select, active low
    output logic sdi_o,            // Data driven toward the block
    output logic sdi_oe_o,         // High while the host drives the data pin
    output logic rd_stb_o,         // One-clock pulse with each read byte
    output logic [7:0] rd_byte_o   // Byte gathered during a read
);
    // Bit order and pin mode as this host last wrote them to setup A
    logic lsb_w;
    logic four_w;

    // Idle levels: clock low, deselected, data pin released
    initial begin
        lsb_w = 1'b0;
        four_w = 1'b0;
        sclk_o = 1'b0;
        csb_n_o = 1'b1;
        sdi_o = 1'b0;
        sdi_oe_o = 1'b0;
        rd_stb_o = 1'b0;
        rd_byte_o = 8'h00;
    end

    // One bit: 4 clk low, 4 clk high; read data is taken 2 clk into the high
    // phase, before the enable can drop after the last rise in single mode
    task automatic put_bit(input logic b, input logic drive, output logic got);
        @(negedge clk_i);
        sclk_o = 1'b0;
        sdi_o = b;
        sdi_oe_o = drive;
        repeat (4) @(negedge clk_i);
        sclk_o = 1'b1;
        repeat (2) @(negedge clk_i);
        got = four_w ? out_pin_i : pin_in_i;
        @(negedge clk_i);
    endtask

    // Whole frame: instruction word, then n bytes written or read
    task automatic frame(input logic rd, input logic [14:0] addr, input int n,
                         input logic [7:0] wd [4]);
        logic [15:0] w;
        logic [7:0] r;
        logic g;
        w = {rd, addr};
        r = 8'h00;
        @(negedge clk_i);
        csb_n_o = 1'b0;
        for (int i = 0; i < 16; i++) put_bit(lsb_w ? w[i] : w[15 - i], 1'b1, g);
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                put_bit(lsb_w ? wd[k][i] : wd[k][7 - i], !rd, g);
                r[lsb_w ? i : 7 - i] = g;
            end
            if (rd) begin
                @(negedge clk_i);
                rd_byte_o = r;
                rd_stb_o = 1'b1;
                @(negedge clk_i);
                rd_stb_o = 1'b0;
            end
        end
        @(negedge clk_i);
        sclk_o = 1'b0;
        sdi_oe_o = 1'b0;
        repeat (4) @(negedge clk_i);
        csb_n_o = 1'b1;
        // New modes apply from the next frame; either reset copy clears them all
        if (!rd && addr == spcc_pkg::SPCC_ADDR_SETUP_A) begin
            if (wd[0][7] | wd[0][0]) begin
                lsb_w = 1'b0;
                four_w = 1'b0;
            end else begin
                lsb_w = wd[0][6] | wd[0][1];
                four_w = wd[0][4] | wd[0][3];
            end
        end
        repeat (8) @(negedge clk_i);
    endtask
endmodule

// File: testbench/spcc_serial_setup_tb.sv
// Self-checking bench for the serial setup block driven by a host model
`timescale 1ns/1ps
module spcc_serial_setup_tb;
    import spcc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic idle_pat = 1'b0;
    logic sclk, csb_n, host_d, host_oe, rd_stb, pin_w, out_w;
    logic in_o, in_oe, out_o, out_oe, dev_rst, cal, div, stall;
    logic [2:0] strobes;
    logic [7:0] rd_byte;
    logic [63:0] active;
    logic [7:0] d [6];
    logic [7:0] exp_rd [$];
    int exp_ev [$];
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    int stall_n = 0;

    initial forever #50 clk_i = ~clk_i;
    // A released line shows a changing pattern, never the last driven value
    always @(negedge clk_i) idle_pat <= ~idle_pat;
    assign pin_w = in_oe ? in_o : (host_oe ? host_d : idle_pat);
    assign out_w = out_oe ? out_o : idle_pat;
    assign strobes = {dev_rst, cal, div};

    spcc_serial_setup #(.BUF_DEPTH(8)) spcc_serial_setup_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sclk_i(sclk), .csb_n_i(csb_n), .serial_in_pin_i(pin_w), .serial_in_pin_o(in_o),
        .serial_in_pin_oe_o(in_oe), .serial_out_pin_o(out_o), .serial_out_pin_oe_o(out_oe),
        .active_regs_o(active), .device_reset_o(dev_rst), .cal_start_o(cal),
        .divider_reset_o(div), .outputs_stall_o(stall));
    spcc_host_model spcc_host_model_inst (.clk_i(clk_i), .pin_in_i(pin_w),
        .out_pin_i(out_w), .sclk_o(sclk),
        .csb_n_o(csb_n), .sdi_o(host_d), .sdi_oe_o(host_oe), .rd_stb_o(rd_stb),
        .rd_byte_o(rd_byte));

    task automatic bad(input string what);
        bad_count++;
        $display("BAD %0t %s", $time, what);
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) bad($sformatf("%s got %h expected %h", what, got, exp));
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] v);
        spcc_host_model_inst.frame(1'b0, a, 1, '{v, 8'h00, 8'h00, 8'h00});
    endtask
    // Expected byte is queued first; the monitor compares it when it arrives
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        spcc_host_model_inst.frame(1'b1, a, 1, '{default: 8'h00});
    endtask
    task automatic end_sim;
        if (exp_rd.size() != 0 || exp_ev.size() != 0) bad("expected results never seen");
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Monitor: read bytes, strobe pulses (2 reset, 1 calibration, 0 divider),
    // stall length and which data pin is driven
    always @(posedge clk_i) begin
        if (rd_stb === 1'b1) begin
            if (exp_rd.size() == 0) bad("unexpected read byte");
            else chk(64'(rd_byte), 64'(exp_rd.pop_front()), "read byte");
        end
        for (int k = 2; k >= 0; k--) begin
            if (strobes[k] === 1'b1) begin
                if (exp_ev.size() == 0) bad("unexpected strobe");
                else chk(64'(k), 64'(exp_ev.pop_front()), "strobe");
            end
        end
        if (stall === 1'b1) stall_n++;
        else if (stall_n != 0) begin
            chk(64'(stall_n), 64'(SPCC_RESYNC_CYCLES), "stall length");
            stall_n = 0;
        end
        if ((spcc_host_model_inst.four_w && in_oe === 1'b1)
            || (!spcc_host_model_inst.four_w && out_oe === 1'b1)) bad("wrong pin driven");
    end

    // Cut a hang short; all frames together need well under 10000 clocks
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad("timeout");
            end_sim();
        end
    end

    initial begin
        logic [31:0] seed;
        seed = $urandom(32'hFBB2);
        for (int i = 0; i < 6; i++) d[i] = 8'($urandom());
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rd_chk(SPCC_ADDR_SETUP_A, 8'h00);
        rd_chk(SPCC_ADDR_SETUP_B, 8'h00);
        exp_ev.push_back(1);
        exp_ev.push_back(0);
        wr(SPCC_ADDR_SETUP_B, 8'h04);
        exp_ev.push_back(0);
        wr(SPCC_ADDR_SETUP_B, 8'h02);
        rd_chk(SPCC_ADDR_SETUP_B, 8'h00);
        wr(15'h0005, d[5]);
        rd_chk(15'h0005, 8'h00);
        // Descending stream: 0x012, 0x011, 0x010
        spcc_host_model_inst.frame(1'b0, 15'h0012, 3, '{d[0], d[1], d[2], 8'h00});
        chk(active, 64'h0, "active before update");
        rd_chk(15'h0010, 8'h00);
        wr(SPCC_ADDR_SETUP_B, 8'h20);
        rd_chk(15'h0010, d[2]);
        rd_chk(15'h0012, d[0]);
        wr(SPCC_ADDR_UPDATE, 8'h02);
        chk(active, 64'h0, "active after wrong key");
        wr(SPCC_ADDR_UPDATE, SPCC_UPDATE_KEY);
        chk(active, {40'h0, d[0], d[1], d[2]}, "active after update");
        exp_ev.push_back(0);
        wr(SPCC_ADDR_SETUP_B, 8'h22);
        rd_chk(SPCC_ADDR_SETUP_B, 8'h20);
        // Only the low copies set: both copies must follow
        wr(SPCC_ADDR_SETUP_A, 8'h06);
        rd_chk(SPCC_ADDR_SETUP_A, 8'h66);
        spcc_host_model_inst.frame(1'b0, 15'h0013, 2, '{d[3], d[4], 8'h00, 8'h00});
        exp_rd.push_back(d[3]);
        exp_rd.push_back(d[4]);
        spcc_host_model_inst.frame(1'b1, 15'h0013, 2, '{default: 8'h00});
        wr(SPCC_ADDR_SETUP_A, 8'h16);
        rd_chk(SPCC_ADDR_SETUP_A, 8'h7E);
        rd_chk(15'h0014, d[4]);
        wr(SPCC_ADDR_SETUP_B, 8'hA0);
        spcc_host_model_inst.frame(1'b0, 15'h0015, 2, '{d[5], ~d[5], 8'h00, 8'h00});
        rd_chk(15'h0015, d[5]);
        rd_chk(15'h0016, 8'h00);
        rd_chk(SPCC_ADDR_SETUP_B, 8'hA0);
        // Either reset copy clears everything, including the modes just set
        for (int i = 0; i < 2; i++) begin
            exp_ev.push_back(2);
            wr(SPCC_ADDR_SETUP_A, (i == 0) ? 8'h80 : 8'h01);
            chk(active, 64'h0, "active after soft reset");
            rd_chk(SPCC_ADDR_SETUP_A, 8'h00);
            rd_chk(SPCC_ADDR_SETUP_B, 8'h00);
        end
        repeat (4) @(negedge clk_i);
        end_sim();
    end
endmodule
